/* File: src/amot_alert.sv */
`timescale 1ns/100ps
// Operation
// - out-of-limit sets sticky bit until gone+read
// - alert low while unmasked fault or unread
// - overtemperature indication is live, not sticky
// - mask blocks alert only, status still sets
// - first mask: bit7 second-register summary, others
// - second mask bits gate second status sources
// - mask bit5 follows shared pin function
// - pin10 alert only when selected, default off
// - config four bits1:0 pick shared pin function
// - overheat enable makes main pin overheat input, shared pin too in overheat pin mode
// - overheat disabled: pins ignore overheat function
// - full-speed bit forces fans while overheat low
// - forcing applies only to running fans
// - timer accumulates only during overheat assertion
// - timer saturates at full scale until cleared
// - bit0 on first assertion, then 22.76ms units
// - reading timer clears it
// - read during assertion restarts at one
// - zero limit re-sets shared flag after read
// - summary bit shows any second-register bit
// - timer above limit sets shared flag in overheat pin mode, else status one bit0
module amot_alert #(
    parameter int unsigned UNIT_CYCLES = amot_pkg::UNIT_CYCLES
) (
    input  wire logic                clk_i,
    input  wire logic                reset_i,
    input  wire amot_pkg::amot_req_s reg_req_i,
    output logic [7:0]               reg_rdata_o,
    input  wire logic [6:0]          status_one_fault_i,
    input  wire logic [7:0]          status_two_fault_i,
    input  wire logic                general_io_six_event_i,
    input  wire logic                overheat_signal_pin_i,
    input  wire logic                shared_pin_i,
    input  wire logic                second_pulse_drive_i,
    input  wire logic [3:0]          fan_running_i,
    output logic                     pin10_out_o,
    output logic                     pin10_oe_o,
    output logic                     shared_pin_out_o,
    output logic                     shared_pin_oe_o,
    output logic [3:0]               full_speed_on_overheat_o
);
    localparam int CW = $clog2(UNIT_CYCLES + 1);

    logic [7:0]                 mask_one_q;
    logic [7:0]                 mask_two_q;
    logic [7:0]                 cfg_three_q;
    logic [7:0]                 limit_q;
    amot_pkg::amot_pin_mode_e   pin_mode_q;
    logic [6:0]                 s1_q;
    logic [7:0]                 s2_q;
    logic [1:0]                 sync1_q;
    logic [1:0]                 sync2_q;
    logic [1:0]                 sync3_q;
    logic [1:0]                 pins_q;
    logic [CW-1:0]              unit_cnt_q;
    logic [7:0]                 units_q;
    logic                       seen_q;

    logic       rd_s1;
    logic       rd_s2;
    logic       rd_tmr;
    logic       overheat;
    logic       shared_overheat;
    logic       limit_hit;
    logic [7:0] timer_val;
    logic [6:0] c1;
    logic [7:0] c2;
    logic [7:0] s2_view;
    logic       alert_any;

    function automatic logic is_rd(input amot_pkg::amot_req_s r, input logic [7:0] a);
        return r.rd && (r.addr == a);
    endfunction

    assign rd_s1  = is_rd(reg_req_i, amot_pkg::ADDR_STATUS_ONE);
    assign rd_s2  = is_rd(reg_req_i, amot_pkg::ADDR_STATUS_TWO);
    assign rd_tmr = is_rd(reg_req_i, amot_pkg::ADDR_TIMER);

    // writable registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask_one_q  <= amot_pkg::RST_MASK;
            mask_two_q  <= amot_pkg::RST_MASK;
            cfg_three_q <= amot_pkg::RST_CFG;
            limit_q     <= amot_pkg::RST_LIMIT;
            pin_mode_q  <= amot_pkg::PIN_TACH;
        end else if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                amot_pkg::ADDR_MASK_ONE:  mask_one_q  <= reg_req_i.wdata;
                amot_pkg::ADDR_MASK_TWO:  mask_two_q  <= reg_req_i.wdata;
                amot_pkg::ADDR_CFG_THREE: cfg_three_q <= reg_req_i.wdata;
                amot_pkg::ADDR_LIMIT:     limit_q     <= reg_req_i.wdata;
                amot_pkg::ADDR_CFG_FOUR:  pin_mode_q  <= amot_pkg::amot_pin_mode_e'(reg_req_i.wdata[1:0]);
                default: ;
            endcase
        end
    end

    // pins are asynchronous; a level counts once stages two and three agree
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q <= amot_pkg::RST_PINS;
            sync2_q <= amot_pkg::RST_PINS;
            sync3_q <= amot_pkg::RST_PINS;
            pins_q  <= amot_pkg::RST_PINS;
        end else begin
            sync1_q <= {shared_pin_i, overheat_signal_pin_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 2; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pins_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // active low inputs; enable bit gates both pins
    assign shared_overheat = (pin_mode_q == amot_pkg::PIN_OVERHEAT);
    assign overheat = cfg_three_q[amot_pkg::CFG3_OVERHEAT_EN]
                      && (!pins_q[amot_pkg::PIN_MAIN]
                          || (shared_overheat && !pins_q[amot_pkg::PIN_SHARED]));

    // assertion timer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            unit_cnt_q <= '0;
            units_q    <= '0;
            seen_q     <= 1'b0;
        end else if (rd_tmr) begin
            unit_cnt_q <= '0;
            units_q    <= '0;
            seen_q     <= overheat;
        end else if (overheat) begin
            seen_q <= 1'b1;
            if (unit_cnt_q == CW'(UNIT_CYCLES - 1)) begin
                unit_cnt_q <= '0;
                if (units_q != amot_pkg::TIMER_FULL) begin
                    units_q <= units_q + 8'h01;
                end
            end else begin
                unit_cnt_q <= unit_cnt_q + CW'(1);
            end
        end
    end

    // below one full unit the register still shows the first assertion
    assign timer_val = (units_q == 8'h00) ? {7'h00, seen_q} : units_q;
    assign limit_hit = cfg_three_q[amot_pkg::CFG3_OVERHEAT_EN] && (timer_val > limit_q);

    always_comb begin
        c1 = status_one_fault_i;
        if (cfg_three_q[amot_pkg::CFG3_OVERHEAT_EN]) begin
            c1[0] = limit_hit && !shared_overheat;
        end
        c2 = status_two_fault_i;
        unique case (pin_mode_q)
            amot_pkg::PIN_TACH:     c2[amot_pkg::S2_SHARED] = status_two_fault_i[amot_pkg::S2_SHARED];
            amot_pkg::PIN_OVERHEAT: c2[amot_pkg::S2_SHARED] = limit_hit;
            amot_pkg::PIN_ALERT:    c2[amot_pkg::S2_SHARED] = 1'b0;
            amot_pkg::PIN_GPIO:     c2[amot_pkg::S2_SHARED] = general_io_six_event_i;
        endcase
    end

    // sticky status: a fault present in the read cycle keeps its bit
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= rd_s1 ? c1 : (s1_q | c1);
            s2_q <= rd_s2 ? c2 : (s2_q | c2);
        end
    end

    // overtemperature bit reads the live level
    always_comb begin
        s2_view = s2_q;
        s2_view[amot_pkg::S2_OVERTEMP] = status_two_fault_i[amot_pkg::S2_OVERTEMP];
    end

    assign alert_any = (|(s1_q & ~mask_one_q[6:0]))
                       || (!mask_one_q[amot_pkg::S1_SUMMARY] && (|(s2_view & ~mask_two_q)));

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin10_out_o              <= 1'b0;
            pin10_oe_o               <= 1'b0;
            shared_pin_out_o         <= 1'b0;
            shared_pin_oe_o          <= 1'b0;
            full_speed_on_overheat_o <= '0;
        end else begin
            // open drain alert pulls low; otherwise pin10 carries the fan drive
            if (cfg_three_q[amot_pkg::CFG3_ALERT_SEL]) begin
                pin10_out_o <= 1'b0;
                pin10_oe_o  <= alert_any;
            end else begin
                pin10_out_o <= second_pulse_drive_i;
                pin10_oe_o  <= 1'b1;
            end
            shared_pin_out_o <= 1'b0;
            shared_pin_oe_o  <= (pin_mode_q == amot_pkg::PIN_ALERT) && alert_any;
            full_speed_on_overheat_o <= {4{cfg_three_q[amot_pkg::CFG3_FULL_SPEED] && overheat}}
                                        & fan_running_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else begin
            unique case (reg_req_i.addr)
                amot_pkg::ADDR_STATUS_ONE: reg_rdata_o <= {|s2_view, s1_q};
                amot_pkg::ADDR_STATUS_TWO: reg_rdata_o <= s2_view;
                amot_pkg::ADDR_MASK_ONE:   reg_rdata_o <= mask_one_q;
                amot_pkg::ADDR_MASK_TWO:   reg_rdata_o <= mask_two_q;
                amot_pkg::ADDR_CFG_THREE:  reg_rdata_o <= cfg_three_q;
                amot_pkg::ADDR_TIMER:      reg_rdata_o <= timer_val;
                amot_pkg::ADDR_LIMIT:      reg_rdata_o <= limit_q;
                amot_pkg::ADDR_CFG_FOUR:   reg_rdata_o <= {6'h00, pin_mode_q};
                default:                   reg_rdata_o <= 8'h00;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence rd_during_s;
        rd_tmr && overheat;
    endsequence

    sticky_hold_a: assert property (s1_q[4] && !rd_s1 |=> s1_q[4])
        else $error("status bit dropped without read");
    alert_pin_a: assert property (cfg_three_q[0] && !reg_req_i.wr |=> pin10_oe_o == $past(alert_any))
        else $error("pin10 alert does not follow status");
    overtemp_live_a: assert property (reg_req_i.addr == amot_pkg::ADDR_STATUS_TWO && !status_two_fault_i[1]
        |=> !reg_rdata_o[amot_pkg::S2_OVERTEMP])
        else $error("overtemperature indication held");
    masked_status_a: assert property (status_one_fault_i[3] && mask_one_q[3] |=> s1_q[3])
        else $error("masked source lost its status");
    summary_mask_a: assert property (mask_one_q[7] && s1_q == 7'h00 |-> !alert_any)
        else $error("summary mask failed");
    pin10_drive_a: assert property (!cfg_three_q[0] && !reg_req_i.wr
        |=> pin10_oe_o && pin10_out_o == $past(second_pulse_drive_i))
        else $error("pin10 not carrying fan drive");
    full_speed_on_overheat_a: assert property (cfg_three_q[2] && overheat && fan_running_i[0] |=> full_speed_on_overheat_o[0])
        else $error("fan not forced on overheat");
    idle_fan_a: assert property (!fan_running_i[1] |=> !full_speed_on_overheat_o[1])
        else $error("idle fan forced");
    timer_pause_a: assert property (!overheat && !rd_tmr |=> $stable(timer_val))
        else $error("timer moved without overheat");
    timer_sat_a: assert property (units_q == 8'hff && !rd_tmr |=> units_q == 8'hff)
        else $error("timer left full scale");
    clear_read_a: assert property (rd_tmr && !overheat |=> timer_val == 8'h00)
        else $error("timer not cleared by read");
    read_during_a: assert property (rd_during_s |=> timer_val == 8'h01)
        else $error("timer not restarted at one");
    zero_limit_a: assert property (rd_during_s ##0 (limit_q == 8'h00 && shared_overheat && !reg_req_i.wr)
        |-> ##2 s2_q[5])
        else $error("zero limit did not set shared flag");

    // status and alert
    status_clear_a: assert property (rd_s1 && c1 == 7'h00 |=> s1_q == 7'h00)
        else $error("status one not cleared by read");
    write_refused_a: assert property (reg_req_i.wr && !reg_req_i.rd && c1 == 7'h00
        && reg_req_i.addr == amot_pkg::ADDR_STATUS_ONE |=> s1_q == $past(s1_q))
        else $error("status one changed by a write");
    summary_bit_a: assert property (reg_req_i.addr == amot_pkg::ADDR_STATUS_ONE
        |=> reg_rdata_o[amot_pkg::S1_SUMMARY] == ($past(s2_view) != 8'h00))
        else $error("summary bit does not follow status two");
    shared_alert_a: assert property (pin_mode_q == amot_pkg::PIN_ALERT && alert_any && !reg_req_i.wr
        |=> shared_pin_oe_o && !shared_pin_out_o)
        else $error("shared pin not pulling alert low");
    shared_mask_a: assert property (cfg_three_q[0] && !mask_one_q[7] && !mask_two_q[5] && s2_q[5]
        && !reg_req_i.wr |=> pin10_oe_o)
        else $error("unmasked shared source gave no alert");
    io_source_a: assert property (pin_mode_q == amot_pkg::PIN_GPIO && general_io_six_event_i
        |=> s2_q[amot_pkg::S2_SHARED])
        else $error("general io event not flagged");
    limit_flag_a: assert property (limit_hit && shared_overheat |=> s2_q[amot_pkg::S2_SHARED])
        else $error("timer limit did not set shared flag");
    cfg_four_a: assert property (reg_req_i.wr && reg_req_i.addr == amot_pkg::ADDR_CFG_FOUR
        |=> pin_mode_q == $past(reg_req_i.wdata[1:0]))
        else $error("shared pin function not taken");

    // overheat and timer
    main_overheat_a: assert property (cfg_three_q[1] && cfg_three_q[2] && !pins_q[0] && fan_running_i[2]
        |=> full_speed_on_overheat_o[2])
        else $error("main pin overheat ignored");
    overheat_off_a: assert property (!cfg_three_q[1] |=> full_speed_on_overheat_o == 4'h0)
        else $error("fans forced with overheat disabled");
    timer_off_a: assert property (!cfg_three_q[1] && !rd_tmr |=> $stable(timer_val))
        else $error("timer moved with overheat disabled");
    first_assert_a: assert property (overheat && !rd_tmr |=> timer_val != 8'h00)
        else $error("first assertion not shown");
    timer_step_a: assert property (overheat && !rd_tmr && unit_cnt_q == CW'(UNIT_CYCLES - 1)
        && units_q != amot_pkg::TIMER_FULL |=> units_q == $past(units_q) + 8'h01)
        else $error("timer unit not counted");
    fan_release_a: assert property (!overheat |=> full_speed_on_overheat_o == 4'h0)
        else $error("fans still forced after overheat");
endmodule // amot_alert

/* File: src/amot_pkg.sv */
package amot_pkg;
    // register addresses
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
    localparam logic [7:0] ADDR_MASK_ONE   = 8'h74;
    localparam logic [7:0] ADDR_MASK_TWO   = 8'h75;
    localparam logic [7:0] ADDR_CFG_THREE  = 8'h78;
    localparam logic [7:0] ADDR_TIMER      = 8'h79;
    localparam logic [7:0] ADDR_LIMIT      = 8'h7a;
    localparam logic [7:0] ADDR_CFG_FOUR   = 8'h7d;

    // values after reset
    localparam logic [7:0] RST_MASK    = 8'h00;
    localparam logic [7:0] RST_CFG     = 8'h00;
    localparam logic [7:0] RST_LIMIT   = 8'h00;
    localparam logic [1:0] RST_PINS    = 2'h3;

    // field positions
    localparam int CFG3_ALERT_SEL   = 0;
    localparam int CFG3_OVERHEAT_EN = 1;
    localparam int CFG3_FULL_SPEED  = 2;
    localparam int S1_SUMMARY       = 7;
    localparam int S2_SHARED        = 5;
    localparam int S2_OVERTEMP      = 1;
    localparam int PIN_MAIN         = 0;
    localparam int PIN_SHARED       = 1;

    localparam logic [7:0] TIMER_FULL = 8'hff;

    // timer resolution
    localparam longint UNIT_TIME_NS    = 22760000;
    localparam longint CLK_PERIOD_NS   = 4;
    localparam int     UNIT_CYCLES     = int'(UNIT_TIME_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        PIN_TACH     = 2'b00,
        PIN_OVERHEAT = 2'b01,
        PIN_ALERT    = 2'b10,
        PIN_GPIO     = 2'b11
    } amot_pin_mode_e;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amot_req_s;
endpackage

/* File: tb/amot_host.sv */
`timescale 1ns/100ps
// management host: register requests change at the falling edge only
module amot_host (
    input  wire logic           clk_i,
    output amot_pkg::amot_req_s req_o,
    input  wire logic [7:0]     rdata_i
);
    initial req_o = '0;

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        req_o = '0;
    endtask

    // data is registered on the taking edge, so it is settled by the next fall
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        req_o = '0;
        d = rdata_i;
    endtask
endmodule // amot_host

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic                clk_i = 1'b0;
    logic                reset_i = 1'b1;
    amot_pkg::amot_req_s req;
    logic [7:0]          rdata;
    logic [6:0]          f1 = '0;
    logic [7:0]          f2 = '0;
    logic                pin22 = 1'b1;
    logic                pin14 = 1'b1;
    logic                pwm = 1'b0;
    logic                io_six = 1'b0;
    logic [3:0]          fan_run = 4'h5;
    logic                p10_out, p10_oe, sh_out, sh_oe;
    logic [3:0]          fs;
    logic [7:0]          rv;
    int                  errors = 0;
    int                  tests_run = 0;
    int                  cycles = 0;

    initial forever #2 clk_i = ~clk_i;

    amot_host host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));

    // short timer unit keeps saturation runs brief
    amot_alert #(.UNIT_CYCLES(8)) dut (
        .clk_i(clk_i), .reset_i(reset_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .status_one_fault_i(f1), .status_two_fault_i(f2), .general_io_six_event_i(io_six),
        .overheat_signal_pin_i(pin22), .shared_pin_i(pin14), .second_pulse_drive_i(pwm),
        .fan_running_i(fan_run), .pin10_out_o(p10_out), .pin10_oe_o(p10_oe),
        .shared_pin_out_o(sh_out), .shared_pin_oe_o(sh_oe), .full_speed_on_overheat_o(fs));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rv);
        check(rv, exp);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // overheat pin held low for exactly n cycles
    task automatic pulse(input int n);
        pin22 = 1'b0;
        wait_n(n);
        pin22 = 1'b1;
        wait_n(8);
    endtask

    task automatic t_reset();
        rdc(amot_pkg::ADDR_MASK_ONE, 8'h00);
        rdc(amot_pkg::ADDR_MASK_TWO, 8'h00);
        rdc(amot_pkg::ADDR_CFG_THREE, 8'h00);
        rdc(amot_pkg::ADDR_LIMIT, 8'h00);
        rdc(amot_pkg::ADDR_CFG_FOUR, 8'h00);
        rdc(8'h33, 8'h00);
        pwm = 1'b1;
        wait_n(2);
        check({6'h0, p10_oe, p10_out}, 8'h03);
        pwm = 1'b0;
    endtask

    task automatic t_sticky();
        host.wr(amot_pkg::ADDR_CFG_THREE, 8'h01);
        f1 = 7'h40;
        wait_n(4);
        check({7'h0, p10_oe}, 8'h01);
        f1 = 7'h00;
        wait_n(4);
        check({7'h0, p10_oe}, 8'h01);
        rdc(amot_pkg::ADDR_STATUS_ONE, 8'h40);
        wait_n(3);
        check({7'h0, p10_oe}, 8'h00);
        rdc(amot_pkg::ADDR_STATUS_ONE, 8'h00);
        host.wr(amot_pkg::ADDR_MASK_ONE, 8'h40);
        f1 = 7'h40;
        wait_n(4);
        check({7'h0, p10_oe}, 8'h00);
        rdc(amot_pkg::ADDR_STATUS_ONE, 8'h40);
        f1 = 7'h00;
        host.rd(amot_pkg::ADDR_STATUS_ONE, rv);
        host.wr(amot_pkg::ADDR_MASK_ONE, 8'h00);
    endtask

    task automatic t_second();
        f2 = 8'h08;
        wait_n(4);
        rdc(amot_pkg::ADDR_STATUS_ONE, 8'h80);
        check({7'h0, p10_oe}, 8'h01);
        host.wr(amot_pkg::ADDR_MASK_ONE, 8'h80);
        wait_n(3);
        check({7'h0, p10_oe}, 8'h00);
        host.wr(amot_pkg::ADDR_MASK_ONE, 8'h00);
        host.wr(amot_pkg::ADDR_MASK_TWO, 8'h08);
        wait_n(3);
        check({7'h0, p10_oe}, 8'h00);
        host.wr(amot_pkg::ADDR_MASK_TWO, 8'h00);
        f2 = 8'h00;
        rdc(amot_pkg::ADDR_STATUS_TWO, 8'h08);
        f2 = 8'h02;
        wait_n(4);
        rdc(amot_pkg::ADDR_STATUS_TWO, 8'h02);
        f2 = 8'h00;
        wait_n(2);
        rdc(amot_pkg::ADDR_STATUS_TWO, 8'h00);
    endtask

    task automatic t_shared();
        host.wr(amot_pkg::ADDR_CFG_FOUR, 8'hff);
        rdc(amot_pkg::ADDR_CFG_FOUR, 8'h03);
        io_six = 1'b1;
        wait_n(4);
        rdc(amot_pkg::ADDR_STATUS_TWO, 8'h20);
        check({7'h0, p10_oe}, 8'h01);
        host.wr(amot_pkg::ADDR_MASK_TWO, 8'h20);
        wait_n(3);
        check({7'h0, p10_oe}, 8'h00);
        io_six = 1'b0;
        host.rd(amot_pkg::ADDR_STATUS_TWO, rv);
        host.wr(amot_pkg::ADDR_MASK_TWO, 8'h00);
        host.wr(amot_pkg::ADDR_CFG_FOUR, 8'h02);
        f1 = 7'h01;
        wait_n(4);
        check({6'h0, sh_oe, sh_out}, 8'h02);
        f1 = 7'h00;
        host.rd(amot_pkg::ADDR_STATUS_ONE, rv);
        wait_n(3);
        check({7'h0, sh_oe}, 8'h00);
        host.wr(amot_pkg::ADDR_CFG_FOUR, 8'h00);
    endtask

    task automatic t_timer();
        pulse(20);
        rdc(amot_pkg::ADDR_TIMER, 8'h00);
        host.wr(amot_pkg::ADDR_CFG_THREE, 8'h06);
        host.rd(amot_pkg::ADDR_TIMER, rv);
        pulse(4);
        rdc(amot_pkg::ADDR_TIMER, 8'h01);
        pin22 = 1'b0;
        wait_n(10);
        check({4'h0, fs}, 8'h05);
        wait_n(4);
        pin22 = 1'b1;
        wait_n(8);
        check({4'h0, fs}, 8'h00);
        pulse(14);
        rdc(amot_pkg::ADDR_TIMER, 8'h03);
        rdc(amot_pkg::ADDR_TIMER, 8'h00);
        pulse(2100);
        rdc(amot_pkg::ADDR_TIMER, 8'hff);
    endtask

    task automatic t_limit();
        host.wr(amot_pkg::ADDR_CFG_THREE, 8'h07);
        host.wr(amot_pkg::ADDR_CFG_FOUR, 8'h01);
        host.rd(amot_pkg::ADDR_STATUS_TWO, rv);
        host.rd(amot_pkg::ADDR_STATUS_ONE, rv);
        pin14 = 1'b0;
        wait_n(30);
        host.rd(amot_pkg::ADDR_TIMER, rv);
        rdc(amot_pkg::ADDR_TIMER, 8'h01);
        rdc(amot_pkg::ADDR_STATUS_TWO, 8'h20);
        check({7'h0, p10_oe}, 8'h01);
        host.wr(amot_pkg::ADDR_MASK_TWO, 8'h20);
        wait_n(3);
        check({7'h0, p10_oe}, 8'h00);
        pin14 = 1'b1;
        wait_n(8);
        host.rd(amot_pkg::ADDR_TIMER, rv);
        host.rd(amot_pkg::ADDR_STATUS_TWO, rv);
        rdc(amot_pkg::ADDR_STATUS_TWO, 8'h00);
        host.wr(amot_pkg::ADDR_MASK_TWO, 8'h00);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard: the longest scenario needs about 2200 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("[FAIL] %0t run did not finish", $time);
            stop_test();
        end
    end

    initial begin
        wait_n(20);
        reset_i = 1'b0;
        t_reset();
        t_sticky();
        t_second();
        t_shared();
        t_timer();
        t_limit();
        stop_test();
    end
endmodule // tb_top
